// ===== rtl/ipm_pkg.sv
package ipm_pkg;

  // Configuration byte width
  localparam int IPM_CFG_W = 8;
  // Host address width seen by the chip select decoder
  localparam int IPM_ADDR_W = 10;
  // Lowest host address bit compared against a decode register
  localparam int IPM_DEC_LSB = 2;
  // Position of the disk/infrared select bit in config_reg_16
  localparam int IPM_SEL_BIT = 1;
  // Position of the three-mode enable bit in config_reg_9
  localparam int IPM_3MODE_BIT = 5;
  // A decode register holding this value decodes nothing
  localparam logic [IPM_CFG_W-1:0] IPM_DEC_OFF = 8'h00;

  // Shared pin group settings
  localparam logic IPM_MODE_DISK = 1'b0;
  localparam logic IPM_MODE_IR = 1'b1;

  // Reset and idle levels
  localparam logic IPM_RST_DISK_RESET_N = 1'b0;
  localparam logic IPM_INACTIVE_N = 1'b1;
  localparam logic IPM_IR_IDLE = 1'b1;
  localparam logic IPM_OFF = 1'b0;

  // Clock rate and step pulse timing
  localparam int IPM_CLK_MHZ = 250;
  localparam int IPM_NS_PER_US = 1000;
  localparam int IPM_STEP_PULSE_NS = 1000;
  // Least time, so round up to whole cycles
  localparam int IPM_STEP_PULSE_CYC =
    (IPM_STEP_PULSE_NS * IPM_CLK_MHZ + IPM_NS_PER_US - 1) / IPM_NS_PER_US;
  localparam int IPM_STEP_CNT_W = 12;

  // Floppy open-drain pin group, one bit per pin
  typedef struct packed {
    logic step;
    logic dir;
    logic head;
    logic reduced_write_current;
    logic wdata;
  } ipm_fdd_s;

  // All floppy pins released
  localparam ipm_fdd_s IPM_FDD_RELEASED = '0;

  // Step pulse generator states
  typedef enum logic [1:0] {
    IPM_STEP_IDLE,
    IPM_STEP_PULSE,
    IPM_STEP_GAP
  } ipm_step_e;

endpackage

// ===== rtl/ipm_sync3.sv
`timescale 1ns/1ps
module ipm_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Asynchronous pin level
  input wire logic pin_in,
  // Filtered level in the clock domain
  output logic level_out
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  logic level_d;

  // Accept a change only once stages two and three agree
  always_comb begin
    level_d = level_out;
    if (ff2_q == ff3_q) begin
      level_d = ff3_q;
    end
  end

  // Chain; the first stage feeds only the second
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ff1_q <= RST_VAL;
      ff2_q <= RST_VAL;
      ff3_q <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      ff1_q <= pin_in;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      level_out <= level_d;
    end
  end

endmodule

// ===== rtl/ipm_pin_mux.sv
`timescale 1ns/1ps
// Summary of operation
// - Select low: first pin is disk reset
// - Select high: first pin is interrupt G
// - Select low: second pin is buffer enable
// - Select high: second pin is interrupt H
// - Secondary select decodes config_reg_22 range
// - Primary select decodes config_reg_21 range
// - Select high: secondary pin sends infrared
// - Select high: primary pin receives infrared
// - Fast infrared pin: receive input or mode select
// - Direction high outward, low inward
// - Three-mode bit changes write current meaning
// - Precompensated write data sent active low
// - One low step pulse per track
module ipm_pin_mux
  import ipm_pkg::*;
#(
  parameter int ADDR_W = ipm_pkg::IPM_ADDR_W,
  parameter int STEP_CYC = ipm_pkg::IPM_STEP_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Configuration bytes
  input wire logic [ipm_pkg::IPM_CFG_W-1:0] config_reg_16_in,
  input wire logic [ipm_pkg::IPM_CFG_W-1:0] config_reg_9_in,
  input wire logic [ipm_pkg::IPM_CFG_W-1:0] config_reg_21_in,
  input wire logic [ipm_pkg::IPM_CFG_W-1:0] config_reg_22_in,
  // Host address
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic host_addr_valid_in,
  // Hard disk requests, active high
  input wire logic disk_reset_req_in,
  input wire logic disk_buffer_req_in,
  // Interrupt sources for the shared pins
  input wire logic irq_g_in,
  input wire logic irq_h_in,
  // Infrared sources and configuration
  input wire logic ir_tx_second_in,
  input wire logic ir_mode_sel_0_drive_in,
  input wire logic ir_mode_sel_0_in,
  // Pin inputs from outside
  input wire logic fast_ir_pin_in,
  input wire logic disk_sel_primary_pin_in,
  // Floppy core requests
  input wire logic step_req_in,
  input wire logic dir_outward_in,
  input wire logic head_side1_in,
  input wire logic rate_500k_in,
  input wire logic rwc_three_mode_in,
  input wire logic write_serial_data_in,
  // Shared disk/infrared pins
  output logic disk_reset_n_out,
  output logic disk_buffer_en_n_out,
  output logic disk_sel_secondary_n_out,
  output logic disk_sel_primary_n_out,
  output logic disk_sel_primary_oe_out,
  // Fast infrared pin
  output logic ir_mode_sel_0_out,
  output logic ir_mode_sel_0_oe_out,
  // Received infrared data
  output logic fast_ir_rx_out,
  output logic ir_rx_second_out,
  // Mode status
  output logic three_mode_enable_out,
  // Floppy open-drain pins
  output ipm_pkg::ipm_fdd_s fdd_pin_out,
  output ipm_pkg::ipm_fdd_s fdd_oe_out
);

  import ipm_pkg::*;

  // Decoded configuration
  logic mode_ir, three_mode, pri_hit, sec_hit;
  // Synchronised pin levels
  logic fast_ir_lvl, pri_pin_lvl;
  // Next values of the registered pins
  logic pin1_d, pin2_d, sec_d, pri_d, pri_oe_d;
  logic sel0_d, sel0_oe_d, fast_rx_d, rx2_d;
  ipm_fdd_s fdd_oe_d;
  // Step pulse generator
  ipm_step_e step_state_q, step_state_d;
  logic [IPM_STEP_CNT_W-1:0] step_cnt_q, step_cnt_d;
  localparam logic [IPM_STEP_CNT_W-1:0] STEP_LAST = IPM_STEP_CNT_W'(STEP_CYC - 1);

  // Pin synchronisers
  ipm_sync3 #(.RST_VAL(IPM_IR_IDLE)) u_sync_fast_ir (
    .clk_in(clk_in), .reset_in(reset_in), .pin_in(fast_ir_pin_in), .level_out(fast_ir_lvl)
  );

  ipm_sync3 #(.RST_VAL(IPM_IR_IDLE)) u_sync_rx2 (
    .clk_in(clk_in), .reset_in(reset_in),
    .pin_in(disk_sel_primary_pin_in), .level_out(pri_pin_lvl)
  );

  // Configuration bits and address decode
  always_comb begin
    mode_ir = config_reg_16_in[IPM_SEL_BIT];
    three_mode = config_reg_9_in[IPM_3MODE_BIT];
    // A zero register disables its window so a blank setup selects nothing
    pri_hit = host_addr_valid_in && (config_reg_21_in != IPM_DEC_OFF) &&
              (host_addr_in[ADDR_W-1:IPM_DEC_LSB] == config_reg_21_in);
    sec_hit = host_addr_valid_in && (config_reg_22_in != IPM_DEC_OFF) &&
              (host_addr_in[ADDR_W-1:IPM_DEC_LSB] == config_reg_22_in);
  end

  // Shared pin steering; only the chosen function is routed
  always_comb begin
    if (mode_ir == IPM_MODE_DISK) begin
      pin1_d = !disk_reset_req_in;
      pin2_d = !disk_buffer_req_in;
      sec_d = !sec_hit;
      pri_d = !pri_hit;
      pri_oe_d = 1'b1;
      rx2_d = IPM_IR_IDLE;
    end else begin
      pin1_d = irq_g_in;
      pin2_d = irq_h_in;
      sec_d = ir_tx_second_in;
      // Primary pin turns into an input here
      pri_d = IPM_INACTIVE_N;
      pri_oe_d = 1'b0;
      rx2_d = pri_pin_lvl;
    end
  end

  // Fast infrared pin direction
  always_comb begin
    if (ir_mode_sel_0_drive_in) begin
      sel0_d = ir_mode_sel_0_in;
      sel0_oe_d = 1'b1;
      // Own output would echo back, so report idle instead
      fast_rx_d = IPM_IR_IDLE;
    end else begin
      sel0_d = IPM_OFF;
      sel0_oe_d = 1'b0;
      fast_rx_d = fast_ir_lvl;
    end
  end

  // Floppy open-drain levels; enable high pulls the pin low
  always_comb begin
    fdd_oe_d = IPM_FDD_RELEASED;
    fdd_oe_d.dir = !dir_outward_in;
    fdd_oe_d.head = head_side1_in;
    fdd_oe_d.reduced_write_current = three_mode ? !rwc_three_mode_in : !rate_500k_in;
    fdd_oe_d.wdata = write_serial_data_in;
    fdd_oe_d.step = (step_state_q == IPM_STEP_PULSE);
  end

  // Step pulse sequencing; a gap equal to the pulse keeps pulses apart
  always_comb begin
    step_state_d = step_state_q;
    step_cnt_d = step_cnt_q;
    case (step_state_q)
      IPM_STEP_IDLE: begin
        // Requests are only taken while idle
        if (step_req_in) begin
          step_state_d = IPM_STEP_PULSE;
          step_cnt_d = '0;
        end
      end
      IPM_STEP_PULSE, IPM_STEP_GAP: begin
        // Pulse and gap share one counter, so both last STEP_CYC cycles
        if (step_cnt_q == STEP_LAST) begin
          step_state_d = (step_state_q == IPM_STEP_PULSE) ? IPM_STEP_GAP : IPM_STEP_IDLE;
          step_cnt_d = '0;
        end else begin
          step_cnt_d = step_cnt_q + 1'b1;
        end
      end
      default: begin
        step_state_d = IPM_STEP_IDLE;
        step_cnt_d = '0;
      end
    endcase
  end

  // Output and state registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // Hold the hard disk in reset while the chip is in reset
      disk_reset_n_out <= IPM_RST_DISK_RESET_N;
      disk_buffer_en_n_out <= IPM_INACTIVE_N;
      disk_sel_secondary_n_out <= IPM_INACTIVE_N;
      disk_sel_primary_n_out <= IPM_INACTIVE_N;
      disk_sel_primary_oe_out <= 1'b1;
      ir_mode_sel_0_out <= IPM_OFF;
      ir_mode_sel_0_oe_out <= 1'b0;
      fast_ir_rx_out <= IPM_IR_IDLE;
      ir_rx_second_out <= IPM_IR_IDLE;
      three_mode_enable_out <= IPM_OFF;
      fdd_pin_out <= IPM_FDD_RELEASED;
      fdd_oe_out <= IPM_FDD_RELEASED;
      step_state_q <= IPM_STEP_IDLE;
      step_cnt_q <= '0;
    end else begin
      disk_reset_n_out <= pin1_d;
      disk_buffer_en_n_out <= pin2_d;
      disk_sel_secondary_n_out <= sec_d;
      disk_sel_primary_n_out <= pri_d;
      disk_sel_primary_oe_out <= pri_oe_d;
      ir_mode_sel_0_out <= sel0_d;
      ir_mode_sel_0_oe_out <= sel0_oe_d;
      fast_ir_rx_out <= fast_rx_d;
      ir_rx_second_out <= rx2_d;
      three_mode_enable_out <= three_mode;
      // Open-drain pins only ever drive low
      fdd_pin_out <= IPM_FDD_RELEASED;
      fdd_oe_out <= fdd_oe_d;
      step_state_q <= step_state_d;
      step_cnt_q <= step_cnt_d;
    end
  end

  // Step pulse length and an out-of-reset marker, read only by checks
  logic [IPM_STEP_CNT_W-1:0] chk_len_q;
  logic chk_run_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      chk_len_q <= '0;
      chk_run_q <= 1'b0;
    end else begin
      chk_len_q <= fdd_oe_out.step ? chk_len_q + 1'b1 : '0;
      chk_run_q <= 1'b1;
    end
  end

  // Outputs still hold reset levels at the first edge after release, so checks skip it
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !chk_run_q);

  sequence s_disk_mode;
    !$past(config_reg_16_in[IPM_SEL_BIT]);
  endsequence
  sequence s_ir_mode;
    $past(config_reg_16_in[IPM_SEL_BIT]);
  endsequence
  sequence s_step_taken;
    (step_state_q == IPM_STEP_IDLE) && step_req_in;
  endsequence

  property p_disk_reset;
    s_disk_mode |-> disk_reset_n_out == !$past(disk_reset_req_in);
  endproperty
  a_disk_reset: assert property (p_disk_reset)
    else $error("Disk reset pin wrong in disk mode");
  property p_irq_g;
    s_ir_mode |-> disk_reset_n_out == $past(irq_g_in);
  endproperty
  a_irq_g: assert property (p_irq_g)
    else $error("Interrupt G not on first shared pin");
  property p_buffer_en;
    s_disk_mode |-> disk_buffer_en_n_out == !$past(disk_buffer_req_in);
  endproperty
  a_buffer_en: assert property (p_buffer_en)
    else $error("Buffer enable pin wrong in disk mode");
  property p_irq_h;
    s_ir_mode |-> disk_buffer_en_n_out == $past(irq_h_in);
  endproperty
  a_irq_h: assert property (p_irq_h)
    else $error("Interrupt H not on second shared pin");
  property p_sec_sel;
    s_disk_mode |-> disk_sel_secondary_n_out == !($past(host_addr_valid_in) &&
      ($past(config_reg_22_in) != IPM_DEC_OFF) &&
      ($past(host_addr_in[ADDR_W-1:IPM_DEC_LSB]) == $past(config_reg_22_in)));
  endproperty
  a_sec_sel: assert property (p_sec_sel)
    else $error("Secondary select decode mismatch");
  property p_pri_sel;
    s_disk_mode |-> !disk_sel_primary_n_out == ($past(host_addr_valid_in) &&
      ($past(config_reg_21_in) != IPM_DEC_OFF) &&
      ($past(host_addr_in[ADDR_W-1:IPM_DEC_LSB]) == $past(config_reg_21_in)))
      && disk_sel_primary_oe_out;
  endproperty
  a_pri_sel: assert property (p_pri_sel)
    else $error("Primary select decode mismatch");
  property p_ir_tx2;
    s_ir_mode |-> disk_sel_secondary_n_out == $past(ir_tx_second_in);
  endproperty
  a_ir_tx2: assert property (p_ir_tx2)
    else $error("Second infrared transmit not on secondary pin");
  property p_ir_rx2;
    s_ir_mode |-> !disk_sel_primary_oe_out && ir_rx_second_out == $past(pri_pin_lvl);
  endproperty
  a_ir_rx2: assert property (p_ir_rx2)
    else $error("Primary pin not released for infrared receive");
  property p_fast_ir;
    ir_mode_sel_0_oe_out == $past(ir_mode_sel_0_drive_in) &&
      (ir_mode_sel_0_oe_out ? ir_mode_sel_0_out == $past(ir_mode_sel_0_in)
                            : fast_ir_rx_out == $past(fast_ir_lvl));
  endproperty
  a_fast_ir: assert property (p_fast_ir)
    else $error("Fast infrared pin direction wrong");
  property p_dir_head;
    fdd_oe_out.dir == !$past(dir_outward_in) && fdd_oe_out.head == $past(head_side1_in);
  endproperty
  a_dir_head: assert property (p_dir_head)
    else $error("Direction or head level wrong");
  property p_rwc;
    !$past(config_reg_9_in[IPM_3MODE_BIT]) |-> fdd_oe_out.reduced_write_current == !$past(rate_500k_in);
  endproperty
  a_rwc: assert property (p_rwc)
    else $error("Write current level does not follow rate");
  property p_three_mode;
    $past(config_reg_9_in[IPM_3MODE_BIT]) |->
      three_mode_enable_out && fdd_oe_out.reduced_write_current == !$past(rwc_three_mode_in);
  endproperty
  a_three_mode: assert property (p_three_mode)
    else $error("Three-mode write current meaning not applied");
  property p_wdata;
    fdd_oe_out.wdata == $past(write_serial_data_in) && fdd_pin_out == IPM_FDD_RELEASED;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("Write data not driven low for a data bit");
  property p_step_start;
    s_step_taken |=> ##1 fdd_oe_out.step;
  endproperty
  a_step_start: assert property (p_step_start)
    else $error("Step pulse did not start after request");
  property p_step_len;
    $fell(fdd_oe_out.step) |-> $past(chk_len_q) == STEP_LAST;
  endproperty
  a_step_len: assert property (p_step_len)
    else $error("Step pulse length wrong");
  property p_exclusive;
    s_disk_mode |-> ir_rx_second_out == IPM_IR_IDLE;
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("Infrared receive leaked in disk mode");

endmodule

// ===== verification/ipm_far_side.sv
`timescale 1ns/1ps
// Far side of the pins: floppy drive pull-ups, disk select pin and infrared module
module ipm_far_side
  import ipm_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Device pins
  input wire ipm_pkg::ipm_fdd_s fdd_pin_in,
  input wire ipm_pkg::ipm_fdd_s fdd_oe_in,
  input wire logic primary_n_in,
  input wire logic primary_oe_in,
  input wire logic mode_sel_in,
  input wire logic mode_sel_oe_in,
  // Levels the infrared module sends
  input wire logic ir_rx_level_in,
  input wire logic fast_ir_level_in,
  // Resolved wire levels
  output ipm_pkg::ipm_fdd_s fdd_wire_out,
  output logic primary_pin_out,
  output logic fast_ir_pin_out,
  // Step pulses seen and width of the last one in cycles
  output int step_count_out,
  output int step_width_out
);
  // Cycles the step wire has been low so far
  int low_run;

  // Open-drain wires: drive pulls low, otherwise the pull-up wins
  assign fdd_wire_out = ipm_fdd_s'((fdd_pin_in & fdd_oe_in) | ~fdd_oe_in);
  // Once the device lets go, the infrared module owns the line
  assign primary_pin_out = primary_oe_in ? primary_n_in : ir_rx_level_in;
  // Shared fast pin: mode select out or fast receive
  assign fast_ir_pin_out = mode_sel_oe_in ? mode_sel_in : fast_ir_level_in;

  // Drive counts each low step pulse as one track
  // Sampled mid-cycle, away from the edge that launches the pin
  initial begin
    step_count_out = 0;
    step_width_out = 0;
    low_run = 0;
    forever begin
      @(negedge clk_in);
      if (fdd_wire_out.step === 1'b0) begin
        low_run++;
      end else if (low_run > 0) begin
        step_count_out++;
        step_width_out = low_run;
        low_run = 0;
      end
    end
  end
endmodule

// ===== verification/tb_ipm_pin_mux.sv
`timescale 1ns/1ps
module tb_ipm_pin_mux;
  import ipm_pkg::*;
  // Short step pulse keeps the run brief
  localparam int STEP = 4;
  logic clk_in, reset_in;
  logic [7:0] config_reg_16, cr9, config_reg_21, config_reg_22;
  logic [9:0] addr;
  logic av, rreq, breq, irq_g, irq_h, tx2, sdrv, sel0, step_req, dir_o, side1, r500, r3, wd;
  logic ir_lvl, fir_lvl, pri_pin, fir_pin;
  logic rst_n, ben_n, sec_n, pri_n, pri_oe, ms0, ms0_oe, fir_rx, rx2, tmode;
  ipm_fdd_s fpin, foe, fwire;
  int steps, swidth, err_count, n_tests;

  ipm_pin_mux #(.ADDR_W(10), .STEP_CYC(STEP)) ipm_pin_mux_inst (
    .clk_in(clk_in), .reset_in(reset_in),
    .config_reg_16_in(config_reg_16), .config_reg_9_in(cr9),
    .config_reg_21_in(config_reg_21), .config_reg_22_in(config_reg_22),
    .host_addr_in(addr), .host_addr_valid_in(av),
    .disk_reset_req_in(rreq), .disk_buffer_req_in(breq),
    .irq_g_in(irq_g), .irq_h_in(irq_h), .ir_tx_second_in(tx2),
    .ir_mode_sel_0_drive_in(sdrv), .ir_mode_sel_0_in(sel0),
    .fast_ir_pin_in(fir_pin), .disk_sel_primary_pin_in(pri_pin),
    .step_req_in(step_req), .dir_outward_in(dir_o), .head_side1_in(side1),
    .rate_500k_in(r500), .rwc_three_mode_in(r3), .write_serial_data_in(wd),
    .disk_reset_n_out(rst_n), .disk_buffer_en_n_out(ben_n),
    .disk_sel_secondary_n_out(sec_n), .disk_sel_primary_n_out(pri_n),
    .disk_sel_primary_oe_out(pri_oe), .ir_mode_sel_0_out(ms0),
    .ir_mode_sel_0_oe_out(ms0_oe), .fast_ir_rx_out(fir_rx), .ir_rx_second_out(rx2),
    .three_mode_enable_out(tmode), .fdd_pin_out(fpin), .fdd_oe_out(foe)
  );

  ipm_far_side ipm_far_side_inst (
    .clk_in(clk_in), .fdd_pin_in(fpin), .fdd_oe_in(foe),
    .primary_n_in(pri_n), .primary_oe_in(pri_oe),
    .mode_sel_in(ms0), .mode_sel_oe_in(ms0_oe),
    .ir_rx_level_in(ir_lvl), .fast_ir_level_in(fir_lvl),
    .fdd_wire_out(fwire), .primary_pin_out(pri_pin), .fast_ir_pin_out(fir_pin),
    .step_count_out(steps), .step_width_out(swidth)
  );

  // Free-running 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Single-bit results
  task automatic chk_bit(input string name, input logic exp, input logic seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Counted results from the far side
  task automatic chk_cnt(input string name, input int exp, input int seen);
    n_tests++;
    if (seen != exp) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset held three cycles; levels checked while still in reset
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk_bit("reset disk_reset_n", 1'b0, rst_n);
    chk_bit("reset selects", 1'b1, sec_n & pri_n & ben_n);
    chk_bit("reset fdd oe", 1'b0, |foe);
    reset_in = 1'b0;
  endtask

  // Model of every pin except the step wire and both receive outputs, from the inputs sampled at the last edge
  task automatic check_pins();
    logic s, h21, h22;
    s = config_reg_16[IPM_SEL_BIT];
    h21 = av && config_reg_21 != 8'h00 && addr[9:2] == config_reg_21;
    h22 = av && config_reg_22 != 8'h00 && addr[9:2] == config_reg_22;
    chk_bit("disk_reset_n", s ? irq_g : !rreq, rst_n);
    chk_bit("disk_buffer_en_n", s ? irq_h : !breq, ben_n);
    chk_bit("disk_sel_secondary", s ? tx2 : !h22, sec_n);
    chk_bit("disk_sel_primary", s ? 1'b1 : !h21, pri_n);
    chk_bit("primary oe", !s, pri_oe);
    chk_bit("mode_sel oe", sdrv, ms0_oe);
    chk_bit("mode_sel", sdrv & sel0, ms0);
    chk_bit("three_mode", cr9[IPM_3MODE_BIT], tmode);
    chk_bit("dir wire", dir_o, fwire.dir);
    chk_bit("head wire", !side1, fwire.head);
    chk_bit("rwc wire", cr9[IPM_3MODE_BIT] ? r3 : r500, fwire.reduced_write_current);
    chk_bit("wdata wire", !wd, fwire.wdata);
    chk_bit("fdd drive level", 1'b0, |fpin);
  endtask

  // Random levels, decode values biased to hit and to disabled windows
  task automatic run_random();
    logic [31:0] r;
    for (int i = 0; i < 300; i++) begin
      r = $urandom;
      {av, rreq, breq, irq_g, irq_h, tx2, sdrv, sel0, dir_o, side1, r500, r3, wd} = r[12:0];
      {ir_lvl, fir_lvl} = r[14:13];
      config_reg_16 = 8'($urandom);
      cr9 = 8'($urandom);
      config_reg_21 = r[15] & r[16] ? 8'h00 : 8'($urandom);
      config_reg_22 = r[17] & r[18] ? 8'h00 : 8'($urandom);
      addr = {r[19] ? config_reg_21 : (r[20] ? config_reg_22 : 8'($urandom)), 2'($urandom)};
      @(negedge clk_in);
      check_pins();
    end
    $display("test random done");
  endtask

  // Five spaced steps plus one request inside a pulse, which is dropped
  task automatic run_step();
    for (int i = 0; i < 5; i++) begin
      step_req = 1'b1;
      @(negedge clk_in);
      step_req = 1'b0;
      repeat (3) @(negedge clk_in);
      step_req = (i == 2);
      @(negedge clk_in);
      step_req = 1'b0;
      repeat (2 * STEP + 1) @(negedge clk_in);
    end
    chk_cnt("step count", 5, steps);
    chk_cnt("step width", STEP, swidth);
    $display("test step done");
  endtask

  // Infrared receive paths through the pin synchronisers
  task automatic run_ir();
    config_reg_16 = 8'h02;
    sdrv = 1'b0;
    for (int v = 0; v < 4; v++) begin
      ir_lvl = v[0];
      fir_lvl = ~v[0];
      repeat (7) @(negedge clk_in);
      chk_bit("ir_rx_second", v[0], rx2);
      chk_bit("fast_ir_rx", ~v[0], fir_rx);
    end
    // Pin turned to output: receive reads idle, wire shows mode select
    sdrv = 1'b1;
    sel0 = 1'b0;
    repeat (7) @(negedge clk_in);
    chk_bit("fast_ir_rx driving", 1'b1, fir_rx);
    chk_bit("fast pin level", 1'b0, fir_pin);
    // Back to disk mode: second receive no longer follows the pin
    ir_lvl = 1'b0;
    config_reg_16 = 8'h00;
    repeat (7) @(negedge clk_in);
    chk_bit("ir_rx_second disk", 1'b1, rx2);
    $display("test ir done");
  endtask

  initial begin
    reset_in = 1'b1;
    {config_reg_16, cr9, config_reg_21, config_reg_22, addr} = '0;
    {av, rreq, breq, irq_g, irq_h, tx2, sdrv, sel0, step_req} = '0;
    {dir_o, side1, r500, r3, wd, ir_lvl, fir_lvl} = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'hef76241d));
    do_reset();
    run_random();
    step_req = 1'b0;
    // Second reset in mid-run before the step traffic
    do_reset();
    run_step();
    run_ir();
    summarize();
  end

  // Tests need about 420 cycles; reaching the 10000-cycle limit means a hang
  initial begin
    #40000;
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
endmodule
